//--- ifp_intc.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ifp_intc #(
  parameter logic [ifp_pkg::NUM_SRC-1:0] SRC_IMPL = ifp_pkg::SRC_IMPL_DEF
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [ifp_pkg::AXI_ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [ifp_pkg::DATA_W-1:0] I_AXI_WDATA,
  input wire logic [ifp_pkg::DATA_W/8-1:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [ifp_pkg::AXI_ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [ifp_pkg::DATA_W-1:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic [ifp_pkg::NUM_SRC-1:0] I_SRC_EVT,
  input wire logic [ifp_pkg::NUM_EXT-1:0] I_EXT_IRQ,
  input wire logic [ifp_pkg::NUM_TRAP-1:0] I_TRAP_EVT,
  input wire logic I_CPU_LEVEL_TOP,
  input wire logic I_IRQ_ACK,
  output logic O_IRQ_REQ,
  output logic [ifp_pkg::VEC_W-1:0] O_VECTOR_NUM,
  output logic [ifp_pkg::LEVEL_W-1:0] O_NEW_LEVEL,
  output logic [23:0] O_VECTOR_ADDR,
  output logic [ifp_pkg::LEVEL_W-1:0] O_CPU_LEVEL,
  output logic O_NEST_DISABLE,
  output logic O_IRQ
);
  import ifp_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [REG_W-1:0] ctl_a;
    logic [REG_W-1:0] ctl_b;
    logic [NUM_FLAG_REGS-1:0][REG_W-1:0] flag;
    logic [NUM_FLAG_REGS-1:0][REG_W-1:0] enab;
    logic [NUM_PRIO_REGS-1:0][REG_W-1:0] prio;
    logic [VEC_W-1:0] pending_vector_number;
    logic [LEVEL_W-1:0] new_cpu_level;
    logic [PRIO_W-1:0] cpu_level;
    logic level_top;
    logic [NUM_EXT-1:0] ext_prev;
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] evt_mask;
    logic irq;
    logic req;
    logic [23:0] vaddr;
  } ifp_state_s;

  ifp_state_s st;
  ifp_state_s next_st;

  logic rst_n;
  logic [NUM_EXT-1:0] ext_s;
  logic [NUM_SRC*PRIO_W-1:0] prio_flat;
  logic [NUM_SRC-1:0] arb_req;
  logic arb_valid;
  logic [VEC_W-1:0] arb_vec;
  logic [LEVEL_W-1:0] arb_level;

  // ****************************************************************
  // reset and pin synchronisers
  // ****************************************************************
  ifp_sync2 #(.WIDTH(1)) u_rst_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESETN),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  ifp_sync2 #(.WIDTH(NUM_EXT)) u_ext_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_d(I_EXT_IRQ),
    .o_q(ext_s)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [DATA_W-1:0] d,
                                             input logic [DATA_W/8-1:0] be);
    logic [REG_W-1:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // writable bits of one priority word; empty sources and gaps stay zero
  function automatic logic [REG_W-1:0] prio_mask(input int n);
    logic [REG_W-1:0] m;
    m = '0;
    if ((n != PRIO_GAP_A) && (n != PRIO_GAP_B)) begin
      for (int f = 0; f < FIELDS_PER_PRIO; f++) begin
        if (SRC_IMPL[n*FIELDS_PER_PRIO + f]) begin
          m[f*PRIO_STRIDE +: PRIO_STRIDE] = PRIO_WMASK[f*PRIO_STRIDE +: PRIO_STRIDE];
        end
      end
    end
    return m;
  endfunction

  function automatic logic [AXI_ADDR_W-1:0] word_addr(input logic [AXI_ADDR_W-1:0] a);
    return {a[AXI_ADDR_W-1:2], 2'b00};
  endfunction

  // returns {hit, data}
  function automatic logic [DATA_W:0] read_word(input logic [AXI_ADDR_W-1:0] a);
    logic [DATA_W:0] r;
    logic [AXI_ADDR_W-1:0] w;
    r = '0;
    w = word_addr(a);
    if (w == RA_CTL_A) begin
      r = {1'b1, 16'h0000, st.ctl_a};
    end else if (w == RA_CTL_B) begin
      r = {1'b1, 16'h0000, st.ctl_b};
    end else if (w == RA_VEC_LEVEL) begin
      r[DATA_W] = 1'b1;
      r[PENDING_VECTOR_NUMBER_LSB +: VEC_W] = st.pending_vector_number;
      r[ILR_LSB +: LEVEL_W] = st.new_cpu_level;
    end else if (w == RA_STATUS_WORD) begin
      r[DATA_W] = 1'b1;
      r[SW_LEVEL_LSB +: PRIO_W] = st.cpu_level;
    end else if (w == RA_CORE_CTL) begin
      r[DATA_W] = 1'b1;
      r[CORE_TOP_BIT] = st.level_top;
    end else if (w == RA_EVT_STATUS) begin
      r[DATA_W] = 1'b1;
      r[NUM_EVT-1:0] = st.evt;
    end else if (w == RA_EVT_MASK) begin
      r[DATA_W] = 1'b1;
      r[NUM_EVT-1:0] = st.evt_mask;
    end
    for (int k = 0; k < NUM_FLAG_REGS; k++) begin
      if (w == RA_FLAG0 + AXI_ADDR_W'(k*RA_STRIDE)) begin
        r = {1'b1, 16'h0000, st.flag[k]};
      end
      if (w == RA_ENAB0 + AXI_ADDR_W'(k*RA_STRIDE)) begin
        r = {1'b1, 16'h0000, st.enab[k]};
      end
    end
    for (int n = 0; n < NUM_PRIO_REGS; n++) begin
      if (w == RA_PRIO0 + AXI_ADDR_W'(n*RA_STRIDE)) begin
        r = {1'b1, 16'h0000, st.prio[n]};
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // arbitration
  // ****************************************************************
  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) begin
      prio_flat[s*PRIO_W +: PRIO_W] =
        st.prio[s/FIELDS_PER_PRIO][(s%FIELDS_PER_PRIO)*PRIO_STRIDE +: PRIO_W];
    end
    arb_req = st.flag & st.enab;
  end

  ifp_prio_arb #(.N(NUM_SRC)) u_arb (
    .i_req(arb_req),
    .i_prio(prio_flat),
    .i_cur_level({st.level_top, st.cpu_level}),
    .o_valid(arb_valid),
    .o_vec(arb_vec),
    .o_level(arb_level)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic wr_go;
    logic wr_hit;
    logic [AXI_ADDR_W-1:0] wa;
    logic [DATA_W:0] rd;
    logic [NUM_SRC-1:0] set;
    logic [NUM_EXT-1:0] ext_edge;
    logic new_req;
    wr_go = 1'b0;
    wr_hit = 1'b0;
    wa = '0;
    rd = '0;
    set = '0;
    ext_edge = '0;
    new_req = 1'b0;
    next_st = st;

    // write channel: address and data in either order
    if (st.awready && I_AXI_AWVALID) begin
      next_st.awready = 1'b0;
      next_st.aw_held = 1'b1;
      next_st.waddr = I_AXI_AWADDR;
    end
    if (st.wready && I_AXI_WVALID) begin
      next_st.wready = 1'b0;
      next_st.w_held = 1'b1;
      next_st.wdata = I_AXI_WDATA;
      next_st.wstrb = I_AXI_WSTRB;
    end
    wr_go = st.aw_held && st.w_held && !st.bvalid;
    wa = word_addr(st.waddr);
    wr_hit = read_word(st.waddr) >> DATA_W != '0;
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.bvalid && I_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // read channel, one cycle after the address is taken
    if (st.arready && I_AXI_ARVALID) begin
      rd = read_word(I_AXI_ARADDR);
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd[DATA_W-1:0];
      next_st.rresp = rd[DATA_W] ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && I_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // external pins: edge selected per pin
    next_st.ext_prev = ext_s;
    for (int k = 0; k < NUM_EXT; k++) begin
      ext_edge[k] = st.ctl_b[CTL_B_POL_LSB + k] ? (st.ext_prev[k] & ~ext_s[k])
                                                : (~st.ext_prev[k] & ext_s[k]);
    end
    set = I_SRC_EVT;
    for (int k = 0; k < NUM_EXT; k++) begin
      set[EXT_VEC[k]] = set[EXT_VEC[k]] | ext_edge[k];
    end

    // global controls; trap set wins over a clearing write
    if (wr_go && (wa == RA_CTL_A)) begin
      next_st.ctl_a = merge(st.ctl_a, st.wdata, st.wstrb);
    end
    next_st.ctl_a = (next_st.ctl_a |
                     (REG_W'(I_TRAP_EVT) << CTL_A_TRAP_LSB)) & CTL_A_WMASK;
    if (wr_go && (wa == RA_CTL_B)) begin
      next_st.ctl_b = merge(st.ctl_b, st.wdata, st.wstrb) & CTL_B_WMASK;
    end

    // flags: hardware only sets, software write may clear
    for (int k = 0; k < NUM_FLAG_REGS; k++) begin
      if (wr_go && (wa == RA_FLAG0 + AXI_ADDR_W'(k*RA_STRIDE))) begin
        next_st.flag[k] = merge(st.flag[k], st.wdata, st.wstrb);
      end
      next_st.flag[k] = (next_st.flag[k] | set[k*REG_W +: REG_W]) &
                        SRC_IMPL[k*REG_W +: REG_W];
      if (wr_go && (wa == RA_ENAB0 + AXI_ADDR_W'(k*RA_STRIDE))) begin
        next_st.enab[k] = merge(st.enab[k], st.wdata, st.wstrb) &
                          SRC_IMPL[k*REG_W +: REG_W];
      end
    end
    for (int n = 0; n < NUM_PRIO_REGS; n++) begin
      if (wr_go && (wa == RA_PRIO0 + AXI_ADDR_W'(n*RA_STRIDE))) begin
        next_st.prio[n] = merge(st.prio[n], st.wdata, st.wstrb) & prio_mask(n);
      end
    end

    // cpu level: software write, raised when the core takes a request
    if (wr_go && (wa == RA_STATUS_WORD) && st.wstrb[0]) begin
      next_st.cpu_level = st.wdata[SW_LEVEL_LSB +: PRIO_W];
    end
    if (I_IRQ_ACK && st.req) begin
      next_st.cpu_level = st.ctl_a[CTL_A_NEST_BIT] ? MAX_USER_LEVEL[PRIO_W-1:0]
                                                   : st.new_cpu_level[PRIO_W-1:0];
    end
    next_st.level_top = I_CPU_LEVEL_TOP;

    // latch winner; vector table entry is base plus two per vector
    next_st.req = arb_valid;
    new_req = arb_valid && (!st.req || (arb_vec != st.pending_vector_number));
    if (arb_valid) begin
      next_st.pending_vector_number = arb_vec;
      next_st.new_cpu_level = arb_level;
      next_st.vaddr = (st.ctl_b[CTL_B_ALT_BIT] ? VEC_ALT_BASE : VEC_PRI_BASE) +
                      {16'h0000, arb_vec, 1'b0};
    end

    // event status: write one to clear, new events win
    if (wr_go && (wa == RA_EVT_STATUS) && st.wstrb[0]) begin
      next_st.evt = st.evt & ~st.wdata[NUM_EVT-1:0];
    end
    next_st.evt[EVT_NEW_REQ] = next_st.evt[EVT_NEW_REQ] | new_req;
    next_st.evt[EVT_TRAP] = next_st.evt[EVT_TRAP] | (|I_TRAP_EVT);
    if (wr_go && (wa == RA_EVT_MASK) && st.wstrb[0]) begin
      next_st.evt_mask = st.wdata[NUM_EVT-1:0];
    end
    next_st.irq = |(next_st.evt & next_st.evt_mask);
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign O_AXI_AWREADY = st.awready;
  assign O_AXI_WREADY = st.wready;
  assign O_AXI_BRESP = st.bresp;
  assign O_AXI_BVALID = st.bvalid;
  assign O_AXI_ARREADY = st.arready;
  assign O_AXI_RDATA = st.rdata;
  assign O_AXI_RRESP = st.rresp;
  assign O_AXI_RVALID = st.rvalid;
  assign O_IRQ_REQ = st.req;
  assign O_VECTOR_NUM = st.pending_vector_number;
  assign O_NEW_LEVEL = st.new_cpu_level;
  assign O_VECTOR_ADDR = st.vaddr;
  assign O_CPU_LEVEL = {st.level_top, st.cpu_level};
  assign O_NEST_DISABLE = st.ctl_a[CTL_A_NEST_BIT];
  assign O_IRQ = st.irq;
endmodule // ifp_intc

//--- ifp_pkg.sv
// Contract
// - thirty-seven registers: two global controls, six flag, six enable, 22 priority, vector/level.
// - first global control holds nesting disable plus trap source control and status flags.
// - second global control sets external request behaviour and alternate vector table select.
// - hardware sets a source flag on request; only a software write clears it.
// - a source may interrupt the core only while its enable bit is set.
// - each user source has a writable 3-bit priority selecting one of eight levels.
// - vector/level register latches pending vector in 7 bits and new level in 4 bits.
// - flag, enable, priority positions follow ascending vector number; vector 0 uses bit 0.
// - cpu level lives in status word bits 7:5 and software may write it.
// - read-only top level bit in core control joins the three status-word level bits.
// - timer 4 is vector 27, table entries 00004Ah and 00014Ah, second flag bit 11.
// - usb is vector 86, table entries 0000C0h and 0001C0h, sixth flag bit 6.
// - second flag bits 15..9 are uart2 tx/rx, ext2, timer5, timer4, oc4, oc3; bit 8 zero.
// - priority 7 is highest, 1 lowest active, 0 disables the source.
package ifp_pkg;
  localparam int AXI_ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int NUM_SRC = 96;
  localparam int NUM_FLAG_REGS = 6;
  localparam int NUM_PRIO_REGS = 24;
  localparam int FIELDS_PER_PRIO = 4;
  localparam int PRIO_W = 3;
  localparam int PRIO_STRIDE = 4;
  localparam int VEC_W = 7;
  localparam int LEVEL_W = 4;
  localparam int NUM_TRAP = 4;
  localparam int NUM_EXT = 3;

  // byte addresses of the register words
  localparam logic [AXI_ADDR_W-1:0] RA_CTL_A = 12'h000;
  localparam logic [AXI_ADDR_W-1:0] RA_CTL_B = 12'h004;
  localparam logic [AXI_ADDR_W-1:0] RA_FLAG0 = 12'h010;
  localparam logic [AXI_ADDR_W-1:0] RA_ENAB0 = 12'h030;
  localparam logic [AXI_ADDR_W-1:0] RA_PRIO0 = 12'h080;
  localparam logic [AXI_ADDR_W-1:0] RA_VEC_LEVEL = 12'h0e0;
  localparam logic [AXI_ADDR_W-1:0] RA_STATUS_WORD = 12'h0e4;
  localparam logic [AXI_ADDR_W-1:0] RA_CORE_CTL = 12'h0e8;
  localparam logic [AXI_ADDR_W-1:0] RA_EVT_STATUS = 12'h0f0;
  localparam logic [AXI_ADDR_W-1:0] RA_EVT_MASK = 12'h0f4;
  localparam int RA_STRIDE = 4;

  // field positions
  localparam int CTL_A_NEST_BIT = 15;
  localparam int CTL_A_TRAP_LSB = 1;
  localparam logic [REG_W-1:0] CTL_A_WMASK = 16'h801e;
  localparam int CTL_B_ALT_BIT = 15;
  localparam int CTL_B_POL_LSB = 0;
  localparam logic [REG_W-1:0] CTL_B_WMASK = 16'h8007;
  localparam logic [REG_W-1:0] PRIO_WMASK = 16'h7777;
  localparam int PRIO_GAP_A = 14;
  localparam int PRIO_GAP_B = 17;
  localparam int PENDING_VECTOR_NUMBER_LSB = 0;
  localparam int ILR_LSB = 8;
  localparam int SW_LEVEL_LSB = 5;
  localparam int CORE_TOP_BIT = 3;
  localparam int EVT_NEW_REQ = 0;
  localparam int EVT_TRAP = 1;
  localparam int NUM_EVT = 2;

  // sources wired to the external request pins
  localparam logic [NUM_EXT-1:0][VEC_W-1:0] EXT_VEC = {7'h1d, 7'h14, 7'h00};
  // second flag register leaves bits 8 and 5 empty
  localparam logic [NUM_SRC-1:0] SRC_IMPL_DEF = {16'hffff, 16'hffff, 16'hffff, 16'hffff,
                                                16'hfedf, 16'hffff};
  localparam logic [23:0] VEC_PRI_BASE = 24'h000014;
  localparam logic [23:0] VEC_ALT_BASE = 24'h000114;
  localparam logic [LEVEL_W-1:0] MAX_USER_LEVEL = 4'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- ifp_sync2.sv
`timescale 1ns/100ps
module ifp_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ifp_sync_s;

  ifp_sync_s st;
  ifp_sync_s next_st;

  always_comb begin
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.s2;
endmodule // ifp_sync2

//--- ifp_prio_arb.sv
`timescale 1ns/100ps
module ifp_prio_arb #(
  parameter int N = ifp_pkg::NUM_SRC
) (
  input wire logic [N-1:0] i_req,
  input wire logic [N*ifp_pkg::PRIO_W-1:0] i_prio,
  input wire logic [ifp_pkg::LEVEL_W-1:0] i_cur_level,
  output logic o_valid,
  output logic [ifp_pkg::VEC_W-1:0] o_vec,
  output logic [ifp_pkg::LEVEL_W-1:0] o_level
);
  import ifp_pkg::*;

  // ascending scan with strict compare: ties keep the lower vector
  always_comb begin
    logic [PRIO_W-1:0] p;
    logic [PRIO_W-1:0] best;
    p = '0;
    best = '0;
    o_valid = 1'b0;
    o_vec = '0;
    for (int s = 0; s < N; s++) begin
      p = i_prio[s*PRIO_W +: PRIO_W];
      if (i_req[s] && (p != '0) && ({1'b0, p} > i_cur_level) &&
          (!o_valid || (p > best))) begin
        o_valid = 1'b1;
        best = p;
        o_vec = VEC_W'(s);
      end
    end
    o_level = {1'b0, best};
  end
endmodule // ifp_prio_arb

//--- ifp_intc_monitor.sv
`timescale 1ns/100ps
// ****
// port checker
// ****
module ifp_intc_monitor (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic I_AXI_AWVALID,
  input wire logic O_AXI_AWREADY,
  input wire logic I_AXI_WVALID,
  input wire logic O_AXI_WREADY,
  input wire logic O_AXI_BVALID,
  input wire logic [ifp_pkg::AXI_ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  input wire logic O_AXI_ARREADY,
  input wire logic [ifp_pkg::DATA_W-1:0] O_AXI_RDATA,
  input wire logic [1:0] O_AXI_RRESP,
  input wire logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic I_IRQ_ACK,
  input wire logic O_IRQ_REQ,
  input wire logic [ifp_pkg::VEC_W-1:0] O_VECTOR_NUM,
  input wire logic [ifp_pkg::LEVEL_W-1:0] O_NEW_LEVEL,
  input wire logic [23:0] O_VECTOR_ADDR,
  input wire logic [ifp_pkg::LEVEL_W-1:0] O_CPU_LEVEL,
  input wire logic O_NEST_DISABLE
);
  import ifp_pkg::*;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);
  sequence r_take;
    I_AXI_ARVALID && O_AXI_ARREADY;
  endsequence
  sequence r_done;
    O_AXI_RVALID && I_AXI_RREADY;
  endsequence
  req_rise_level_a: assert property (
    $rose(O_IRQ_REQ) |-> O_NEW_LEVEL > O_CPU_LEVEL)
    else $error("request raised without a higher priority");
  new_level_range_a: assert property (
    O_IRQ_REQ |-> O_NEW_LEVEL inside {[4'h1:4'h7]})
    else $error("presented level outside one to seven");
  ack_level_a: assert property (
    I_IRQ_ACK && O_IRQ_REQ |=> {1'b0, O_CPU_LEVEL[2:0]} ==
      ($past(O_NEST_DISABLE) ? 4'h7 : $past(O_NEW_LEVEL)))
    else $error("cpu level not taken from the pending level");
  vector_addr_a: assert property (
    O_IRQ_REQ |-> O_VECTOR_ADDR == VEC_PRI_BASE + {O_VECTOR_NUM, 1'b0}
      || O_VECTOR_ADDR == VEC_ALT_BASE + {O_VECTOR_NUM, 1'b0})
    else $error("vector address does not match the vector");
  req_hold_a: assert property (
    O_IRQ_REQ && !I_IRQ_ACK && !$past(I_IRQ_ACK) && O_AXI_AWREADY && !O_AXI_BVALID
      |=> O_IRQ_REQ)
    else $error("request dropped with no cause");
  write_resp_a: assert property (
    I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY
      |=> !O_AXI_BVALID ##1 O_AXI_BVALID)
    else $error("write response not two cycles after take");
  read_answer_a: assert property (
    r_take |=> O_AXI_RVALID && O_AXI_RDATA[31:16] == 16'h0)
    else $error("read answer late or upper half not zero");
  read_release_a: assert property (
    r_done |=> !O_AXI_RVALID && O_AXI_ARREADY)
    else $error("read channel not released");
  unmapped_read_a: assert property (
    I_AXI_ARVALID && O_AXI_ARREADY && I_AXI_ARADDR inside {12'h008, 12'h0fc}
      |=> O_AXI_RRESP == RESP_SLVERR && O_AXI_RDATA == '0)
    else $error("unmapped read not refused");
endmodule // ifp_intc_monitor

//--- ifp_core_model.sv
`timescale 1ns/100ps
// ****
// core side: takes presented vectors
// ****
module ifp_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [ifp_pkg::VEC_W-1:0] i_vec,
  input wire logic i_ack_en,
  input wire logic [3:0] i_delay,
  input wire logic i_top,
  output logic o_ack,
  output logic o_top,
  output logic [ifp_pkg::VEC_W-1:0] o_taken
);
  import ifp_pkg::*;
  typedef struct packed {
    logic [3:0] wait_cnt;
    logic [1:0] cool;
    logic ack;
    logic top;
    logic [VEC_W-1:0] taken;
  } ifp_core_s;
  ifp_core_s st;
  ifp_core_s next_st;
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.top = i_top;
    if (st.cool != 2'h0) begin
      // let the level update land before another take
      next_st.cool = st.cool - 2'h1;
    end else if (i_req && i_ack_en) begin
      next_st.wait_cnt = st.wait_cnt + 4'h1;
      if (st.wait_cnt >= i_delay) begin
        next_st.ack = 1'b1;
        next_st.taken = i_vec;
        next_st.wait_cnt = 4'h0;
        next_st.cool = 2'h3;
      end
    end else begin
      next_st.wait_cnt = 4'h0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_ack = st.ack;
  assign o_top = st.top;
  assign o_taken = st.taken;
endmodule // ifp_core_model

//--- tb.sv
`timescale 1ns/100ps
// ****
// bench top
// ****
module tb;
  import ifp_pkg::*;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ack_en, top_in;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, seed, rdata;
  logic [95:0] src, rnd;
  logic [2:0] ext;
  logic [3:0] trap, dly, nlev, clev;
  logic awready, wready, bvalid, arready, rvalid, ack, top, req, nest, irq;
  logic [1:0] bresp, rresp;
  logic [6:0] vec, taken;
  logic [23:0] vaddr;
  logic [33:0] re;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt, n_checks, cyc;
  always #5 clk = ~clk;
  ifp_intc i_dut (
    .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_SRC_EVT(src), .I_EXT_IRQ(ext), .I_TRAP_EVT(trap), .I_CPU_LEVEL_TOP(top),
    .I_IRQ_ACK(ack), .O_IRQ_REQ(req), .O_VECTOR_NUM(vec), .O_NEW_LEVEL(nlev),
    .O_VECTOR_ADDR(vaddr), .O_CPU_LEVEL(clev), .O_NEST_DISABLE(nest), .O_IRQ(irq));
  ifp_core_model i_core (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_vec(vec),
    .i_ack_en(ack_en), .i_delay(dly), .i_top(top_in), .o_ack(ack), .o_top(top),
    .o_taken(taken));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge clk);
    bq.push_back(r);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge clk);
    rq.push_back({r, 16'h0, d});
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic wreq(input logic v);
    for (int i = 0; i < 40 && req !== v; i++) @(posedge clk);
    chk("request", 32'(req), 32'(v));
  endtask
  task automatic vchk(input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
    chk("vector", 32'(vec), 32'(v));
    chk("new level", 32'(nlev), 32'(l));
    chk("vector address", 32'(vaddr), 32'(a));
  endtask
  task automatic take(input logic [3:0] d, input logic [6:0] v);
    dly <= d;
    ack_en <= 1'b1;
    for (int i = 0; i < 60 && ack !== 1'b1; i++) @(posedge clk);
    ack_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk("taken vector", 32'(taken), 32'(v));
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // results are judged against the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      re = rq.pop_front();
      chk("read data", rdata, re[31:0]);
      chk("read resp", 32'(rresp), 32'(re[33:32]));
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("write resp", 32'(bresp), 32'(bq.pop_front()));
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      final_report();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ack_en, top_in} = '0;
    {awaddr, araddr, wdata, src, ext, trap, dly} = '0;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    seed = 32'd67;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      rd(RA_FLAG0 + 12'(4 * k), 16'h0);
      rd(RA_ENAB0 + 12'(4 * k), 16'h0);
    end
    rd(RA_CTL_A, 16'h0);
    rd(RA_VEC_LEVEL, 16'h0);
    rd(12'h008, 16'h0, RESP_SLVERR);
    wr(12'h0fc, 32'hffff, RESP_SLVERR);
    rd(RA_PRIO0 + 12'h38, 16'h0);
    wr(RA_FLAG0 + 12'h4, 32'hffffffff);
    rd(RA_FLAG0 + 12'h4, 16'hfedf);
    wr(RA_FLAG0 + 12'h4, 32'h0);
    rd(RA_FLAG0 + 12'h4, 16'h0);
    wr(RA_PRIO0, 32'hffffffff);
    rd(RA_PRIO0, 16'h7777);
    wr(RA_PRIO0, 32'h0);
    wr(RA_CTL_A, 32'hffff);
    rd(RA_CTL_A, 16'h801e);
    wr(RA_CTL_A, 32'h0);
    wr(RA_CTL_B, 32'hffff);
    rd(RA_CTL_B, 16'h8007);
    wr(RA_CTL_B, 32'h4);
    // random requests plus pin edges, pin 2 falling; enables are all off here
    rnd = {xs(), xs(), xs()};
    @(posedge clk);
    src <= rnd;
    ext <= 3'h6;
    @(posedge clk);
    src <= '0;
    repeat (6) @(posedge clk);
    ext <= 3'h0;
    rnd = (rnd | (96'h1 << 20) | (96'h1 << 29)) & SRC_IMPL_DEF;
    for (int k = 0; k < 6; k++) rd(RA_FLAG0 + 12'(4 * k), rnd[16 * k +: 16]);
    chk("request", 32'(req), 32'h0);
    for (int k = 0; k < 6; k++) wr(RA_FLAG0 + 12'(4 * k), 32'h0);
    wr(RA_ENAB0 + 12'h4, 32'h0800);
    wr(RA_ENAB0 + 12'h14, 32'h0040);
    wr(RA_PRIO0 + 12'h18, 32'h4000);
    wr(RA_PRIO0 + 12'h54, 32'h0400);
    @(posedge clk);
    src <= (96'h1 << 27) | (96'h1 << 86);
    @(posedge clk);
    src <= '0;
    wreq(1'b1);
    vchk(7'd27, 4'h4, 24'h00004a);
    wr(RA_PRIO0 + 12'h54, 32'h0500);
    repeat (2) @(posedge clk);
    vchk(7'd86, 4'h5, 24'h0000c0);
    wr(RA_CTL_B, 32'h8000);
    repeat (2) @(posedge clk);
    vchk(7'd86, 4'h5, 24'h0001c0);
    rd(RA_VEC_LEVEL, 16'h0556);
    take(4'h7, 7'd86);
    chk("cpu level", 32'(clev), 32'h5);
    wreq(1'b0);
    rd(RA_STATUS_WORD, 16'h00a0);
    rd(RA_FLAG0 + 12'h14, 16'h0040);
    wr(RA_STATUS_WORD, 32'h0);
    wreq(1'b1);
    wr(RA_PRIO0 + 12'h54, 32'h0);
    repeat (2) @(posedge clk);
    vchk(7'd27, 4'h4, 24'h00014a);
    wr(RA_CTL_A, 32'h8000);
    take(4'h0, 7'd27);
    chk("cpu level", 32'(clev), 32'h7);
    chk("nesting", 32'(nest), 32'h1);
    wr(RA_CTL_A, 32'h0);
    top_in <= 1'b1;
    repeat (3) @(posedge clk);
    wr(RA_STATUS_WORD, 32'h0);
    repeat (3) @(posedge clk);
    chk("cpu level", 32'(clev), 32'h8);
    wreq(1'b0);
    wr(RA_CORE_CTL, 32'h0);
    rd(RA_CORE_CTL, 16'h0008);
    top_in <= 1'b0;
    wreq(1'b1);
    @(posedge clk);
    trap <= 4'h4;
    @(posedge clk);
    trap <= 4'h0;
    rd(RA_CTL_A, 16'h0008);
    rd(RA_EVT_STATUS, 16'h0003);
    chk("interrupt", 32'(irq), 32'h0);
    wr(RA_EVT_MASK, 32'h3);
    repeat (2) @(posedge clk);
    chk("interrupt", 32'(irq), 32'h1);
    wr(RA_EVT_STATUS, 32'h3);
    repeat (2) @(posedge clk);
    chk("interrupt", 32'(irq), 32'h0);
    rd(RA_EVT_STATUS, 16'h0);
    final_report();
  end
endmodule // tb
bind ifp_intc ifp_intc_monitor i_mon (.I_CORE_CLK, .I_RESETN, .I_AXI_AWVALID, .O_AXI_AWREADY,
  .I_AXI_WVALID, .O_AXI_WREADY, .O_AXI_BVALID, .I_AXI_ARADDR, .I_AXI_ARVALID, .O_AXI_ARREADY,
  .O_AXI_RDATA, .O_AXI_RRESP, .O_AXI_RVALID, .I_AXI_RREADY, .I_IRQ_ACK, .O_IRQ_REQ,
  .O_VECTOR_NUM, .O_NEW_LEVEL, .O_VECTOR_ADDR, .O_CPU_LEVEL, .O_NEST_DISABLE);
